// [pkg/elc_regs.svh]
// Register offsets, field masks, reset values and line numbers of the line event controller
// Notes on behaviour
// - 27 edge lines: 16 pins, 11 internal
// - Rising, falling or both edges per line
// - Every line configured independently of others
// - Interrupt mask 1 passes, 0 blocks requests
// - Selected unmasked edge sets pending, raises request
// - Write one clears pending and withdraws request
// - One private pending state bit per line
// - Event mask gives one pulse, pending untouched
// - Events are pulses, interrupts latched pending
// - Software trigger write acts like hardware edge
// - Line requests wake system from low power
// - Lines 16-20: supply, usb, calendar sources
// - Lines 21-26: comparators, serial, timer, display
// - Lines 10-15 share one request, vector 40
// - Lines 23, 24 own vectors 57, 58
`ifndef ELC_REGS_SVH
`define ELC_REGS_SVH

`define ELC_NUM_LINES      27
`define ELC_NUM_PIN_LINES  16
`define ELC_OFS_INT_EN     8'h00
`define ELC_OFS_EVT_EN     8'h04
`define ELC_OFS_RISE_SEL   8'h08
`define ELC_OFS_FALL_SEL   8'h0C
`define ELC_OFS_SW_TRIG    8'h10
`define ELC_OFS_PENDING    8'h14
`define ELC_LINE_MASK      27'h5FF_FFFF
`define ELC_RST_LINES      27'h000_0000
`define ELC_RST_WORD       32'h0000_0000
`define ELC_RST_READY      1'b1
`define ELC_RESP_OKAY      1'b0
`define ELC_SHARED_LO      10
`define ELC_SHARED_HI      15
`define ELC_LINE_SERIAL    23
`define ELC_LINE_TIMER     24
`define ELC_LINE_SUPPLY    16
`define ELC_LINE_USB       17
`define ELC_LINE_CAL_ALARM 18
`define ELC_LINE_CAL_STAMP 19
`define ELC_LINE_CAL_WAKE  20
`define ELC_LINE_CMP_ONE   21
`define ELC_LINE_CMP_TWO   22
`define ELC_LINE_DISPLAY   26
// Edges after reset before the third stage holds a fresh sample
`define ELC_SETTLE_LAST    2'h3
`define ELC_VEC_SHARED     40
`define ELC_VEC_SERIAL     57
`define ELC_VEC_TIMER      58

`endif

// [pkg/elc_pkg.sv]
// Types shared by the line event controller and its per-line edge detector
package elc_pkg;

  // Sources in line order 16..26, line 25 is reserved and has no source
  typedef struct packed {
    logic        displayIrq;
    logic        timerWake;
    logic        serialWake;
    logic        comparatorTwo;
    logic        comparatorOne;
    logic        calWake;
    logic        calStamp;
    logic        calAlarm;
    logic        usbWake;
    logic        supplyMon;
    logic [15:0] pinLine;
  } elc_src_t;

  // Requests toward the processor interrupt controller
  typedef struct packed {
    logic [26:0] lineIrq;
    logic        sharedUpperIrq;
    logic        serialWakeIrq;
    logic        timerWakeIrq;
  } elc_irq_t;

  typedef struct packed {
    logic [2:0] sync;
    logic [1:0] settle;
    logic       stable;
    logic       primed;
    logic       trig;
  } elc_line_st_t;

  typedef struct packed {
    logic [26:0] intEn;
    logic [26:0] evtEn;
    logic [26:0] riseSel;
    logic [26:0] fallSel;
    logic [26:0] swTrig;
    logic [26:0] pending;
    logic [26:0] evtPulse;
    elc_irq_t    irq;
    logic        wake;
    logic        wrEn;
    logic [7:0]  addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } elc_state_t;

endpackage : elc_pkg

// [core/elc_line_edge.sv]
// One line: three-stage synchroniser, settled level and selected edge detection
`timescale 1ns/100ps
`include "elc_regs.svh"
module elc_line_edge
  import elc_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic lineIn,
  input  wire logic riseSel,
  input  wire logic fallSel,
  output logic      trig
);

  elc_line_st_t s_q;
  elc_line_st_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.sync = {s_q.sync[1:0], lineIn};
    s_d.trig = 1'b0;
    if (!s_q.primed) begin
      // Cleared stages would fake a low level, so wait for a real sample
      if (s_q.settle != `ELC_SETTLE_LAST) begin
        s_d.settle = s_q.settle + 2'h1;
      end else if (s_q.sync[1] == s_q.sync[2]) begin
        // First settled level after reset is taken without an edge
        s_d.stable = s_q.sync[2];
        s_d.primed = 1'b1;
      end
    end else if (s_q.sync[1] == s_q.sync[2] && s_q.sync[2] != s_q.stable) begin
      // Level counts only once second and third stage agree
      s_d.stable = s_q.sync[2];
      s_d.trig   = s_q.sync[2] ? riseSel : fallSel;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign trig = s_q.trig;

endmodule : elc_line_edge

// [core/elc_top.sv]
// Line event controller: AHB-Lite registers, 27 edge lines, pending flags and event pulses
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`include "elc_regs.svh"
module elc_top
  import elc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire elc_src_t    lineSrc,
  output elc_irq_t         irqOut,
  output logic      [26:0] eventPulse,
  output logic             wakeRequest
);

  localparam int NL = `ELC_NUM_LINES;

  elc_state_t s_q;
  elc_state_t s_d;

  logic [NL-1:0] lineIn;
  logic [NL-1:0] hwTrig;
  logic [NL-1:0] swHit;
  logic [NL-1:0] pendClr;
  logic [NL-1:0] trigAll;
  logic          addrTaken;

  // Line order: pins, then internal sources; line 25 has no source
  always_comb begin
    lineIn                            = '0;
    lineIn[`ELC_NUM_PIN_LINES-1:0]    = lineSrc.pinLine;
    lineIn[`ELC_LINE_SUPPLY]          = lineSrc.supplyMon;
    lineIn[`ELC_LINE_USB]             = lineSrc.usbWake;
    lineIn[`ELC_LINE_CAL_ALARM]       = lineSrc.calAlarm;
    lineIn[`ELC_LINE_CAL_STAMP]       = lineSrc.calStamp;
    lineIn[`ELC_LINE_CAL_WAKE]        = lineSrc.calWake;
    lineIn[`ELC_LINE_CMP_ONE]         = lineSrc.comparatorOne;
    lineIn[`ELC_LINE_CMP_TWO]         = lineSrc.comparatorTwo;
    lineIn[`ELC_LINE_SERIAL]          = lineSrc.serialWake;
    lineIn[`ELC_LINE_TIMER]           = lineSrc.timerWake;
    lineIn[`ELC_LINE_DISPLAY]         = lineSrc.displayIrq;
  end

  // One detector per line, each with its own select bits
  for (genvar i = 0; i < NL; i++) begin : gLine
    elc_line_edge uEdge (
      .clock   (clock),
      .reset   (reset),
      .lineIn  (lineIn[i]),
      .riseSel (s_q.riseSel[i]),
      .fallSel (s_q.fallSel[i]),
      .trig    (hwTrig[i])
    );
  end

  // Read mux works on the next state, so a read right behind a write sees it
  function automatic logic [31:0] readReg(input logic [7:0] a, input elc_state_t st);
    logic [31:0] r;
    r = `ELC_RST_WORD;
    if (a == `ELC_OFS_INT_EN) begin
      r = {5'h00, st.intEn};
    end else if (a == `ELC_OFS_EVT_EN) begin
      r = {5'h00, st.evtEn};
    end else if (a == `ELC_OFS_RISE_SEL) begin
      r = {5'h00, st.riseSel};
    end else if (a == `ELC_OFS_FALL_SEL) begin
      r = {5'h00, st.fallSel};
    end else if (a == `ELC_OFS_SW_TRIG) begin
      r = {5'h00, st.swTrig};
    end else if (a == `ELC_OFS_PENDING) begin
      r = {5'h00, st.pending};
    end
    return r;
  endfunction : readReg

  assign addrTaken = hsel & htrans[1] & hready;

  always_comb begin
    s_d     = s_q;
    swHit   = '0;
    pendClr = '0;

    // Data phase of a write taken in the previous cycle
    if (s_q.wrEn) begin
      if (s_q.addr == `ELC_OFS_INT_EN) begin
        s_d.intEn = hwdata[NL-1:0] & `ELC_LINE_MASK;
      end else if (s_q.addr == `ELC_OFS_EVT_EN) begin
        s_d.evtEn = hwdata[NL-1:0] & `ELC_LINE_MASK;
      end else if (s_q.addr == `ELC_OFS_RISE_SEL) begin
        s_d.riseSel = hwdata[NL-1:0] & `ELC_LINE_MASK;
      end else if (s_q.addr == `ELC_OFS_FALL_SEL) begin
        s_d.fallSel = hwdata[NL-1:0] & `ELC_LINE_MASK;
      end else if (s_q.addr == `ELC_OFS_SW_TRIG) begin
        swHit = hwdata[NL-1:0] & `ELC_LINE_MASK;
      end else if (s_q.addr == `ELC_OFS_PENDING) begin
        pendClr = hwdata[NL-1:0] & `ELC_LINE_MASK;
      end
    end

    // Software request joins the hardware path unchanged
    trigAll = (hwTrig & `ELC_LINE_MASK) | swHit;

    // Software request bit reads back set until its pending flag is cleared
    s_d.swTrig = (s_q.swTrig & ~pendClr) | swHit;

    // Set wins over a clear in the same cycle
    s_d.pending = (s_q.pending & ~pendClr) | (trigAll & s_q.intEn);

    // Event path is a single pulse and never touches pending
    s_d.evtPulse = trigAll & s_q.evtEn;

    // Requests follow the latched flags
    s_d.irq.lineIrq        = s_d.pending;
    s_d.irq.sharedUpperIrq = |s_d.pending[`ELC_SHARED_HI:`ELC_SHARED_LO];
    s_d.irq.serialWakeIrq  = s_d.pending[`ELC_LINE_SERIAL];
    s_d.irq.timerWakeIrq   = s_d.pending[`ELC_LINE_TIMER];

    // Wake stays up while any flag is pending or an event fires
    s_d.wake = (|s_d.pending) | (|s_d.evtPulse);

    // Address phase; zero wait states, every transfer answered OKAY
    s_d.wrEn      = 1'b0;
    s_d.hreadyout = `ELC_RST_READY;
    s_d.hresp     = `ELC_RESP_OKAY;
    if (addrTaken) begin
      s_d.addr = haddr[7:0];
      s_d.wrEn = hwrite;
      if (!hwrite) begin
        s_d.hrdata = readReg(haddr[7:0], s_d);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q           <= '0;
      s_q.hreadyout <= `ELC_RST_READY;
      s_q.hresp     <= `ELC_RESP_OKAY;
      s_q.hrdata    <= `ELC_RST_WORD;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata      = s_q.hrdata;
  assign hreadyout   = s_q.hreadyout;
  assign hresp       = s_q.hresp;
  assign irqOut      = s_q.irq;
  assign eventPulse  = s_q.evtPulse;
  assign wakeRequest = s_q.wake;

  logic unusedBits;
  assign unusedBits = ^{haddr[31:8], hsize, hwdata[31:NL]};

endmodule : elc_top

// [verif/elc_src_model.sv]
// Peripheral and pin sources feeding the line inputs
`timescale 1ns/100ps
module elc_src_model
  import elc_pkg::*;
(
  input  wire logic [26:0] lvl,
  output elc_src_t         src
);
  // Line 25 has no source, so its level is dropped
  // Pin levels arrive as if the port selectors were already programmed
  assign src = {lvl[26], lvl[24:0]};
endmodule : elc_src_model

// [verif/elc_chk_assertions.sv]
// Concurrent checks on the controller outputs
`timescale 1ns/100ps
module elc_chk
  import elc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  input  wire elc_irq_t    irqOut,
  input  wire logic [26:0] eventPulse,
  input  wire logic        wakeRequest
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_ready_high: assert property (hreadyout) else $error("bus stalled");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_pulse_single: assert property ((|eventPulse) |=> (eventPulse & $past(eventPulse)) == 27'h0)
    else $error("event pulse longer than one cycle");
  a_shared_or: assert property (irqOut.sharedUpperIrq == |irqOut.lineIrq[15:10])
    else $error("shared request mismatch");
  a_serial_vec: assert property (irqOut.serialWakeIrq == irqOut.lineIrq[23])
    else $error("serial wake request mismatch");
  a_timer_vec: assert property (irqOut.timerWakeIrq == irqOut.lineIrq[24])
    else $error("timer wake request mismatch");
  a_line_reserved: assert property (!irqOut.lineIrq[25] && !eventPulse[25])
    else $error("reserved line active");
  a_wake_any: assert property (wakeRequest == (|irqOut.lineIrq || |eventPulse))
    else $error("wake request mismatch");
  cover property (irqOut.sharedUpperIrq);
  cover property (irqOut.serialWakeIrq);
  cover property (eventPulse[0]);
endmodule : elc_chk

bind elc_top elc_chk i_chk (.clock(clock), .reset(reset), .hreadyout(hreadyout), .hresp(hresp),
  .irqOut(irqOut), .eventPulse(eventPulse), .wakeRequest(wakeRequest));

// [verif/tb_top.sv]
// Register and edge tests of the line event controller
`timescale 1ns/100ps
module tb_top
  import elc_pkg::*;
;
  logic        clock;
  logic        reset;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  elc_src_t    lineSrc;
  elc_irq_t    irqOut;
  logic [26:0] eventPulse;
  logic        wakeRequest;
  logic [26:0] lvl;
  logic [31:0] q;
  int          error_cnt;
  int          compares;
  int          cyc;
  int          evCnt;
  int          e0;
  // Lines 0, 12 and 23: pin, shared group and serial wake
  localparam logic [31:0] LN = 32'h0080_1001;

  elc_top i_dut (.clock(clock), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .lineSrc(lineSrc), .irqOut(irqOut),
    .eventPulse(eventPulse), .wakeRequest(wakeRequest));
  elc_src_model i_src (.lvl(lvl), .src(lineSrc));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic close_out();
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; holds each phase until hready is seen
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xf

  always @(posedge clock) begin
    if (eventPulse[0] === 1'b1) evCnt <= evCnt + 1;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hwdata = 0;
    lvl = 0;
    reset = 1;
    repeat (2) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      xf(0, 8'(i * 4), 0);
      chk(q, 0);
    end
    xf(1, 8'h00, 32'hFFFF_FFFF);
    xf(0, 8'h00, 0);
    chk(q, 32'h05FF_FFFF);
    xf(1, 8'h00, LN & 32'h0080_1000);
    xf(1, 8'h04, 32'h1);
    // Software request on lines 0, 3 and 12; only 12 may latch
    xf(1, 8'h10, 32'h0000_1009);
    repeat (4) @(posedge clock);
    chk({31'h0, wakeRequest}, 32'h1);
    xf(0, 8'h14, 0);
    chk(q, 32'h0000_1000);
    chk(32'(evCnt), 1);
    xf(0, 8'h10, 0);
    chk(q, 32'h0000_1009);
    xf(1, 8'h14, 32'h0000_1000);
    xf(0, 8'h14, 0);
    chk(q, 0);
    chk({31'h0, wakeRequest}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      xf(1, 8'h08, m[0] ? LN : 0);
      xf(1, 8'h0C, m[1] ? LN : 0);
      for (int e = 0; e < 2; e++) begin
        xf(1, 8'h14, 32'h07FF_FFFF);
        e0 = evCnt;
        lvl <= e ? 27'h0 : LN[26:0];
        repeat (8) @(posedge clock);
        chk({30'h0, irqOut.sharedUpperIrq, irqOut.serialWakeIrq}, {30'h0, {2{m[e]}}});
        xf(0, 8'h14, 0);
        chk(q, m[e] ? 32'h0080_1000 : 0);
        chk(32'(evCnt - e0), 32'(m[e]));
      end
    end
    // Level held high across a reset is no edge; a later rise is
    lvl <= LN[26:0];
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    xf(1, 8'h08, LN);
    xf(1, 8'h00, LN);
    repeat (8) @(posedge clock);
    xf(0, 8'h14, 0);
    chk(q, 0);
    lvl <= 27'h0;
    repeat (8) @(posedge clock);
    lvl <= LN[26:0];
    repeat (8) @(posedge clock);
    xf(0, 8'h14, 0);
    chk(q, 32'h0080_1001);
    close_out();
  end
endmodule : tb_top
